/* File: rea_map.svh */
`ifndef REA_MAP_SVH
`define REA_MAP_SVH

// ==========================================================
// register byte offsets
`define REA_OFF_GAIN_A       8'h00
`define REA_OFF_FGAIN_A      8'h0c
`define REA_OFF_OFFSET_A     8'h18
`define REA_OFF_THR_HIGH     8'h24
`define REA_OFF_THR_LOW      8'h28
`define REA_OFF_PHASE_SIGN   8'h2c
`define REA_OFF_EVENT_FLAGS  8'h30
`define REA_OFF_EVENT_ENABLE 8'h34
`define REA_OFF_ENERGY_A     8'h38
`define REA_OFF_LCY_MODE     8'h44
`define REA_PHASE_STRIDE     8'h04

// ==========================================================
// field positions
`define REA_BIT_HALF_FULL    2
`define REA_BIT_SIGN_CHG_A   10
`define REA_BIT_NEGATIVE_A   4
`define REA_BIT_CLR_ON_READ  6
`define REA_BIT_HALF_MARK    30
`define REA_GAIN_FRAC        23

// ==========================================================
// reset values
`define REA_RST_WORD         32'h0000_0000
`define REA_RST_FIELD24      24'h00_0000
`define REA_RST_LCY          8'h00

// ==========================================================
// timing
`define REA_SAMPLE_PERIOD_NS 125000
`define REA_CLK_PERIOD_NS    100
`define REA_SAMPLE_CYCLES    ((`REA_SAMPLE_PERIOD_NS) / (`REA_CLK_PERIOD_NS))

`endif

/* File: rea_pkg.sv */
`default_nettype none
package rea_pkg;

  // instantaneous total reactive power, one word per phase
  typedef struct packed {
    logic signed [23:0] c;
    logic signed [23:0] b;
    logic signed [23:0] a;
  } rea_power_t;

  typedef logic signed [23:0] rea_field24_t;
  typedef logic signed [47:0] rea_acc_t;
  typedef logic signed [31:0] rea_count_t;

endpackage
`default_nettype wire

/* File: rea_top.sv */
// Notes on behaviour
// - power is scaled by one plus gain over 2^23, gain signed 24-bit.
// - gain 0xc00000 halves power, 0x400000 raises it by half.
// - gain and offset read as 32 bits, top four zero, 28-bit sign extension.
// - signed 24-bit per-phase offset is added to the reactive power.
// - every 125 us each phase power adds into a signed first-stage accumulator.
// - magnitude reaching threshold emits one pulse and removes the threshold.
// - pulse takes accumulator sign; a differing sign raises a sign-change event.
// - pulses count into 32-bit signed counters, read out through energy registers.
// - negative pulses decrement the energy count, positive ones increment it.
// - threshold is two words, upper eight bits of each read zero.
// - energy counters wrap freely both up and down.
// - half-full flag sets when a pulse toggles bit 30 of any energy counter.
// - enabled half-full flag pulls the interrupt request low.
// - sign-change flags at bits 12, 11, 10 for phases c, b, a.
// - sign bits 6, 5, 4 update with the flags; 1 means negative.
// - enable bits 12, 11, 10 route sign-change flags to the interrupt.
// - writing one clears a flag; interrupt returns high when none enabled.
// - with clear-on-read set, energy registers clear after each read.
// - positive angle gives positive sign, negative angle negative sign.
`timescale 1ns/1ps
`default_nettype none
`include "rea_map.svh"

module rea_top #(
  parameter int unsigned SAMPLE_CYCLES = `REA_SAMPLE_CYCLES,
  parameter int unsigned ADDR_W        = 8
) (
  input  wire logic                i_clk_sys,
  input  wire logic                i_sys_rst,
  input  wire rea_pkg::rea_power_t i_power,
  input  wire logic [ADDR_W-1:0]   i_reg_addr,
  input  wire logic [31:0]         i_reg_wdata,
  input  wire logic                i_reg_wr,
  input  wire logic                i_reg_rd,
  output logic      [31:0]         o_reg_rdata,
  output logic                     o_interrupt_request_0_n_n,
  output logic      [2:0]          o_energy_pulse,
  output logic      [2:0]          o_pulse_negative
);
  import rea_pkg::*;

  // ========================================================
  // helpers
  function automatic logic signed [27:0] rea_correct(input logic signed [23:0] p,
                                                     input logic signed [23:0] g,
                                                     input logic signed [23:0] o);
    logic signed [27:0] p28;
    logic signed [51:0] prod;
    logic signed [51:0] scaled;
    p28    = {{4{p[23]}}, p};
    prod   = p28 * g;
    scaled = prod >>> `REA_GAIN_FRAC;
    return p28 + scaled[27:0] + {{4{o[23]}}, o};
  endfunction

  function automatic logic [31:0] rea_pad28(input logic [23:0] v);
    return {4'h0, {4{v[23]}}, v};
  endfunction

  function automatic logic rea_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [7:0]        base,
                                   input int unsigned       idx);
    return addr == ADDR_W'(base + 8'(idx) * `REA_PHASE_STRIDE);
  endfunction

  // ========================================================
  // sample strobe divider
  logic [15:0] div_cnt;
  logic [15:0] next_div_cnt;
  logic        sample_stb;
  logic        next_sample_stb;

  always_comb begin
    next_sample_stb = (div_cnt == 16'(SAMPLE_CYCLES - 1));
    next_div_cnt    = next_sample_stb ? 16'h0000 : div_cnt + 16'h0001;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      div_cnt    <= 16'h0000;
      sample_stb <= 1'b0;
    end else begin
      div_cnt    <= next_div_cnt;
      sample_stb <= next_sample_stb;
    end
  end

  // ========================================================
  // configuration and event registers
  rea_field24_t gain      [3];
  rea_field24_t fgain     [3];
  rea_field24_t offs      [3];
  logic [23:0]  thr_high;
  logic [23:0]  thr_low;
  logic [31:0]  flags;
  logic [31:0]  enable;
  logic [7:0]   lcy_mode;
  logic [31:0]  rdata;
  rea_field24_t next_gain [3];
  rea_field24_t next_fgain[3];
  rea_field24_t next_offs [3];
  logic [23:0]  next_thr_high;
  logic [23:0]  next_thr_low;
  logic [31:0]  next_flags;
  logic [31:0]  next_enable;
  logic [7:0]   next_lcy_mode;
  logic [31:0]  next_rdata;
  logic         next_interrupt_request_0_n_n;
  logic [2:0]   energy_read;
  logic         flags_wr;
  logic [31:0]  evt_set;

  // ========================================================
  // two-stage integration state
  rea_acc_t     acc        [3];
  rea_count_t   cnt        [3];
  logic [2:0]   pulse;
  logic [2:0]   pulse_neg;
  logic [2:0]   neg_sign;
  rea_acc_t     next_acc   [3];
  rea_count_t   next_cnt   [3];
  logic [2:0]   next_pulse;
  logic [2:0]   next_pulse_neg;
  logic [2:0]   next_neg_sign;
  logic [2:0]   sign_evt;
  logic         half_evt;
  logic [47:0]  threshold;
  rea_field24_t pwr        [3];

  assign pwr[0]    = i_power.a;
  assign pwr[1]    = i_power.b;
  assign pwr[2]    = i_power.c;
  assign threshold = {thr_high, thr_low};

  always_comb begin
    logic signed [27:0] corr;
    logic signed [47:0] sum;
    logic        [47:0] mag;
    corr           = 28'sh0;
    sum            = 48'sh0;
    mag            = 48'h0;
    next_acc       = acc;
    next_pulse     = 3'b000;
    next_pulse_neg = pulse_neg;
    next_neg_sign  = neg_sign;
    sign_evt       = 3'b000;
    for (int i = 0; i < 3; i++) begin
      if (sample_stb) begin
        corr        = rea_correct(pwr[i], gain[i], offs[i]);
        sum         = acc[i] + {{20{corr[27]}}, corr};
        next_acc[i] = sum;
        mag         = sum[47] ? 48'(-sum) : 48'(sum);
        if (mag >= threshold) begin
          next_pulse[i]     = 1'b1;
          next_acc[i]       = sum[47] ? sum + $signed(threshold) : sum - $signed(threshold);
          // sign follows the accumulator, so inductive load counts positive
          next_pulse_neg[i] = sum[47];
          next_neg_sign[i]  = sum[47];
          sign_evt[i]       = (sum[47] != neg_sign[i]);
        end
      end
    end
  end

  always_comb begin
    next_cnt = cnt;
    half_evt = 1'b0;
    for (int i = 0; i < 3; i++) begin
      // read-and-clear first so a pulse in the same cycle is kept
      if (energy_read[i] && lcy_mode[`REA_BIT_CLR_ON_READ]) begin
        next_cnt[i] = 32'sh0;
      end
      if (pulse[i]) begin
        next_cnt[i] = pulse_neg[i] ? next_cnt[i] - 32'sh1 : next_cnt[i] + 32'sh1;
        if (next_cnt[i][`REA_BIT_HALF_MARK] != cnt[i][`REA_BIT_HALF_MARK]) begin
          half_evt = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      for (int i = 0; i < 3; i++) begin
        acc[i] <= 48'sh0;
        cnt[i] <= 32'sh0;
      end
      pulse     <= 3'b000;
      pulse_neg <= 3'b000;
      neg_sign  <= 3'b000;
    end else begin
      acc       <= next_acc;
      cnt       <= next_cnt;
      pulse     <= next_pulse;
      pulse_neg <= next_pulse_neg;
      neg_sign  <= next_neg_sign;
    end
  end

  // ========================================================
  // register access
  always_comb begin
    next_gain     = gain;
    next_fgain    = fgain;
    next_offs     = offs;
    next_thr_high = thr_high;
    next_thr_low  = thr_low;
    next_enable   = enable;
    next_lcy_mode = lcy_mode;
    next_rdata    = `REA_RST_WORD;
    energy_read   = 3'b000;
    flags_wr      = i_reg_wr && (i_reg_addr == ADDR_W'(`REA_OFF_EVENT_FLAGS));
    evt_set       = `REA_RST_WORD;
    evt_set[`REA_BIT_HALF_FULL]                 = half_evt;
    evt_set[`REA_BIT_SIGN_CHG_A +: 3]           = sign_evt;
    // set wins over a write-one clear in the same cycle
    next_flags    = (flags & ~(flags_wr ? i_reg_wdata : 32'h0)) | evt_set;
    if (i_reg_wr) begin
      for (int i = 0; i < 3; i++) begin
        if (rea_hit(i_reg_addr, `REA_OFF_GAIN_A, i)) begin
          next_gain[i] = i_reg_wdata[23:0];
        end
        if (rea_hit(i_reg_addr, `REA_OFF_FGAIN_A, i)) begin
          next_fgain[i] = i_reg_wdata[23:0];
        end
        if (rea_hit(i_reg_addr, `REA_OFF_OFFSET_A, i)) begin
          next_offs[i] = i_reg_wdata[23:0];
        end
      end
      case (i_reg_addr)
        ADDR_W'(`REA_OFF_THR_HIGH):     next_thr_high = i_reg_wdata[23:0];
        ADDR_W'(`REA_OFF_THR_LOW):      next_thr_low  = i_reg_wdata[23:0];
        ADDR_W'(`REA_OFF_EVENT_ENABLE): next_enable   = i_reg_wdata;
        ADDR_W'(`REA_OFF_LCY_MODE):     next_lcy_mode = i_reg_wdata[7:0];
        default:                        next_lcy_mode = lcy_mode;
      endcase
    end
    if (i_reg_rd) begin
      for (int i = 0; i < 3; i++) begin
        if (rea_hit(i_reg_addr, `REA_OFF_GAIN_A, i)) begin
          next_rdata = rea_pad28(gain[i]);
        end
        if (rea_hit(i_reg_addr, `REA_OFF_FGAIN_A, i)) begin
          next_rdata = rea_pad28(fgain[i]);
        end
        if (rea_hit(i_reg_addr, `REA_OFF_OFFSET_A, i)) begin
          next_rdata = rea_pad28(offs[i]);
        end
        if (rea_hit(i_reg_addr, `REA_OFF_ENERGY_A, i)) begin
          next_rdata     = cnt[i];
          energy_read[i] = 1'b1;
        end
      end
      case (i_reg_addr)
        ADDR_W'(`REA_OFF_THR_HIGH):     next_rdata = {8'h00, thr_high};
        ADDR_W'(`REA_OFF_THR_LOW):      next_rdata = {8'h00, thr_low};
        ADDR_W'(`REA_OFF_PHASE_SIGN):   next_rdata = 32'({neg_sign, 4'h0});
        ADDR_W'(`REA_OFF_EVENT_FLAGS):  next_rdata = flags;
        ADDR_W'(`REA_OFF_EVENT_ENABLE): next_rdata = enable;
        ADDR_W'(`REA_OFF_LCY_MODE):     next_rdata = {24'h00_0000, lcy_mode};
        default:                        next_rdata = next_rdata;
      endcase
    end
    // request tracks the registered flags, one cycle behind them
    next_interrupt_request_0_n_n = ~|(flags & enable);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      for (int i = 0; i < 3; i++) begin
        gain[i]  <= `REA_RST_FIELD24;
        fgain[i] <= `REA_RST_FIELD24;
        offs[i]  <= `REA_RST_FIELD24;
      end
      thr_high <= `REA_RST_FIELD24;
      thr_low  <= `REA_RST_FIELD24;
      flags    <= `REA_RST_WORD;
      enable   <= `REA_RST_WORD;
      lcy_mode <= `REA_RST_LCY;
      rdata    <= `REA_RST_WORD;
      o_interrupt_request_0_n_n <= 1'b1;
    end else begin
      gain     <= next_gain;
      fgain    <= next_fgain;
      offs     <= next_offs;
      thr_high <= next_thr_high;
      thr_low  <= next_thr_low;
      flags    <= next_flags;
      enable   <= next_enable;
      lcy_mode <= next_lcy_mode;
      rdata    <= next_rdata;
      o_interrupt_request_0_n_n <= next_interrupt_request_0_n_n;
    end
  end

  assign o_reg_rdata      = rdata;
  assign o_energy_pulse   = pulse;
  assign o_pulse_negative = pulse_neg;

  // ========================================================
  // checks
  sequence s_pos_pulse_a;
    pulse[0] && !pulse_neg[0] && !energy_read[0];
  endsequence

  sequence s_neg_pulse_a;
    pulse[0] && pulse_neg[0] && !energy_read[0];
  endsequence

  property p_strobe_single;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      sample_stb |=> !sample_stb;
  endproperty
  a_strobe_single: assert property (p_strobe_single) else $error("sample strobe too long");

  property p_pulse_on_strobe;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (|pulse) |-> $past(sample_stb);
  endproperty
  a_pulse_on_strobe: assert property (p_pulse_on_strobe) else $error("pulse without strobe");

  property p_count_up;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      s_pos_pulse_a |=> cnt[0] == $past(cnt[0]) + 32'sh1;
  endproperty
  a_count_up: assert property (p_count_up) else $error("positive pulse not counted");

  property p_count_down;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      s_neg_pulse_a |=> cnt[0] == $past(cnt[0]) - 32'sh1;
  endproperty
  a_count_down: assert property (p_count_down) else $error("negative pulse not counted");

  property p_wrap_up;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (s_pos_pulse_a and (cnt[0] == 32'sh7fff_ffff)) |=> cnt[0] == 32'sh8000_0000;
  endproperty
  a_wrap_up: assert property (p_wrap_up) else $error("counter did not wrap");

  property p_half_full;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (pulse[0] && next_cnt[0][30] != cnt[0][30]) |=> flags[`REA_BIT_HALF_FULL];
  endproperty
  a_half_full: assert property (p_half_full) else $error("half-full not flagged");

  property p_sign_change;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      sign_evt[0] |=> flags[`REA_BIT_SIGN_CHG_A] && neg_sign[0] == $past(next_neg_sign[0]);
  endproperty
  a_sign_change: assert property (p_sign_change) else $error("sign change lost");

  property p_irq_low;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (|(flags & enable)) |=> !o_interrupt_request_0_n_n;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("enabled flag without request");

  property p_irq_high;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      !(|(flags & enable)) |=> o_interrupt_request_0_n_n;
  endproperty
  a_irq_high: assert property (p_irq_high) else $error("request without enabled flag");

  property p_clear_on_read;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (energy_read[0] && lcy_mode[`REA_BIT_CLR_ON_READ] && !pulse[0]) |=> cnt[0] == 32'sh0;
  endproperty
  a_clear_on_read: assert property (p_clear_on_read) else $error("energy not cleared");

  property p_energy_read;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      energy_read[0] |=> o_reg_rdata == $past(cnt[0]);
  endproperty
  a_energy_read: assert property (p_energy_read) else $error("energy read mismatch");

  property p_thr_pad;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_reg_rd && i_reg_addr == ADDR_W'(`REA_OFF_THR_HIGH)) |=> o_reg_rdata[31:24] == 8'h00;
  endproperty
  a_thr_pad: assert property (p_thr_pad) else $error("threshold pad not zero");

endmodule
`default_nettype wire

/* File: tb_reactive_energy_accumulator.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rea_map.svh"

module tb_reactive_energy_accumulator;
  import rea_pkg::*;

  // ==========================================================
  // short strobe period keeps pulse gaps a few cycles long
  localparam int unsigned SC    = 4;
  localparam logic [7:0]  A_GN  = `REA_OFF_GAIN_A;
  localparam logic [7:0]  A_OFS = `REA_OFF_OFFSET_A;
  localparam logic [7:0]  A_THH = `REA_OFF_THR_HIGH;
  localparam logic [7:0]  A_THL = `REA_OFF_THR_LOW;
  localparam logic [7:0]  A_SGN = `REA_OFF_PHASE_SIGN;
  localparam logic [7:0]  A_FLG = `REA_OFF_EVENT_FLAGS;
  localparam logic [7:0]  A_ENA = `REA_OFF_EVENT_ENABLE;
  localparam logic [7:0]  A_NRG = `REA_OFF_ENERGY_A;
  localparam logic [7:0]  A_LCY = `REA_OFF_LCY_MODE;

  logic        i_clk_sys   = 1'b0;
  logic        i_sys_rst   = 1'b1;
  rea_power_t  i_power     = '0;
  logic [7:0]  i_reg_addr  = 8'h00;
  logic [31:0] i_reg_wdata = 32'h0000_0000;
  logic        i_reg_wr    = 1'b0;
  logic        i_reg_rd    = 1'b0;
  logic [31:0] o_reg_rdata;
  logic        o_interrupt_request_0_n_n;
  logic [2:0]  o_energy_pulse;
  logic [2:0]  o_pulse_negative;
  int          bad_count   = 0;
  int          cmp_count   = 0;
  logic [31:0] rv;
  int          n;
  logic [31:0] gn [3]      = '{32'h0000_0000, 32'h0040_0000, 32'h00c0_0000};
  logic [31:0] th [3]      = '{32'h0000_0064, 32'h0000_012c, 32'h0000_012c};
  int          gp [3]      = '{SC, 2 * SC, 6 * SC};

  rea_top #(
    .SAMPLE_CYCLES (SC),
    .ADDR_W        (8)
  ) dut_u (
    .i_clk_sys        (i_clk_sys),
    .i_sys_rst        (i_sys_rst),
    .i_power          (i_power),
    .i_reg_addr       (i_reg_addr),
    .i_reg_wdata      (i_reg_wdata),
    .i_reg_wr         (i_reg_wr),
    .i_reg_rd         (i_reg_rd),
    .o_reg_rdata      (o_reg_rdata),
    .o_interrupt_request_0_n_n         (o_interrupt_request_0_n_n),
    .o_energy_pulse   (o_energy_pulse),
    .o_pulse_negative (o_pulse_negative)
  );

  always #50 i_clk_sys = ~i_clk_sys;

  // ==========================================================
  // bus and compare tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_rd   <= 1'b0;
    #1;
    d = o_reg_rdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a, rv);
    chk(rv, e);
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge i_clk_sys);
    #1;
  endtask

  // cycles until the next phase a pulse, bounded
  task automatic wait_p(output int c);
    c = 0;
    do begin
      @(posedge i_clk_sys);
      #1;
      c++;
    end while (o_energy_pulse[0] !== 1'b1 && c < 300);
  endtask

  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clk_sys);
    bad_count++;
    close_out();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    // zero threshold pulses every strobe, so energy is checked first
    rdc(A_NRG, 32'h0000_0000);
    wr(A_THL, 32'h0000_0064);
    for (int a = 0; a <= 32'h0000_0044; a += 4) begin
      if (a != 32'h0000_0028 && (a < 32'h0000_0038 || a > 32'h0000_0040)) begin
        rdc(8'(a), 32'h0000_0000);
      end
    end
    rdc(8'h48, 32'h0000_0000);
    wr(A_GN, 32'hff80_0000);
    rdc(A_GN, 32'h0f80_0000);
    wr(A_OFS + 8'h08, 32'h00ff_ffff);
    rdc(A_OFS + 8'h08, 32'h0fff_ffff);
    // restore at once so phase c keeps only a tiny residual
    wr(A_OFS + 8'h08, 32'h0000_0000);
    wr(A_THH, 32'hffff_ffff);
    rdc(A_THH, 32'h00ff_ffff);
    wr(A_THH, 32'h0000_0000);
    rdc(A_THL, 32'h0000_0064);
    // gain scales the pulse rate: full, plus half, minus half
    @(posedge i_clk_sys);
    i_power.a <= 24'h00_0064;
    for (int i = 0; i < 3; i++) begin
      wr(A_GN, gn[i]);
      wr(A_THL, th[i]);
      repeat (3) wait_p(n);
      chk(n, gp[i]);
    end
    @(posedge i_clk_sys);
    i_power <= '0;
    wr(A_GN, 32'h0000_0000);
    wr(A_LCY, 32'h0000_0040);
    wr(A_THL, 32'h0000_0064);
    rdc(A_LCY, 32'h0000_0040);
    // let the leftover of the gain runs drain below the threshold
    settle(12);
    for (int k = 0; k < 3; k++) begin
      rd(A_NRG + 8'(4 * k), rv);
      rdc(A_NRG + 8'(4 * k), 32'h0000_0000);
    end
    // offset alone drives phase a up by five pulses
    // half the threshold leaves the accumulator empty after each pulse
    wr(A_OFS, 32'h0000_0032);
    repeat (5) wait_p(n);
    wr(A_OFS, 32'h0000_0000);
    chk(o_pulse_negative, 32'h0000_0000);
    settle(10);
    rdc(A_NRG, 32'h0000_0005);
    rdc(A_FLG, 32'h0000_0000);
    wr(A_ENA, 32'h0000_0800);
    // all phases negative together for three pulses
    @(posedge i_clk_sys);
    i_power <= {3{24'hff_ff9c}};
    repeat (3) wait_p(n);
    @(posedge i_clk_sys);
    i_power <= '0;
    settle(10);
    chk(o_pulse_negative, 32'h0000_0007);
    // counting down out of zero flips bit 30, so half-full sets too
    rdc(A_FLG, 32'h0000_1c04);
    rdc(A_SGN, 32'h0000_0070);
    chk(o_interrupt_request_0_n_n, 32'h0000_0000);
    wr(A_FLG, 32'h0000_0000);
    rdc(A_FLG, 32'h0000_1c04);
    wr(A_FLG, 32'h0000_0800);
    settle(3);
    chk(o_interrupt_request_0_n_n, 32'h0000_0001);
    rdc(A_FLG, 32'h0000_1404);
    for (int k = 0; k < 3; k++) begin
      rdc(A_NRG + 8'(4 * k), 32'hffff_fffd);
    end
    rdc(A_NRG, 32'h0000_0000);
    wr(A_ENA, 32'hffff_ffff);
    rdc(A_ENA, 32'hffff_ffff);
    settle(2);
    chk(o_interrupt_request_0_n_n, 32'h0000_0000);
    wr(A_FLG, 32'hffff_ffff);
    settle(2);
    chk(o_interrupt_request_0_n_n, 32'h0000_0001);
    rdc(A_FLG, 32'h0000_0000);
    // back to positive on phase a is a second sign change
    @(posedge i_clk_sys);
    i_power.a <= 24'h00_0064;
    wait_p(n);
    @(posedge i_clk_sys);
    i_power <= '0;
    settle(4);
    rdc(A_FLG, 32'h0000_0400);
    rdc(A_SGN, 32'h0000_0060);
    // reset in mid-run clears enables, flags and the request
    @(posedge i_clk_sys);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    settle(1);
    chk(o_interrupt_request_0_n_n, 32'h0000_0001);
    rdc(A_ENA, 32'h0000_0000);
    rdc(A_FLG, 32'h0000_0000);
    close_out();
  end

endmodule
`default_nettype wire
